//--- cfi_dev.sv
/*
 * Device end: two injection groups plus the front port ingress towards the
 * switch core, and extraction steering towards the external host port.
 * Assumes a switch core stream on the core side, link over cfi_link_if.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cfi_regs.svh"

module cfi_skid #(parameter int W = 9) (
	input  wire logic         sys_clk,
	input  wire logic         rst_b,
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	output logic              out_valid,
	output logic      [W-1:0] out_data,
	input  wire logic         out_ready
);
	logic         skid_v_reg;
	logic [W-1:0] skid_reg;
	// Second entry catches the word in flight when the drain side stalls
	assign in_ready = !skid_v_reg;
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			out_valid  <= 1'b0;
			out_data   <= '0;
			skid_v_reg <= 1'b0;
			skid_reg   <= '0;
		end else if (out_ready || !out_valid) begin
			if (skid_v_reg) begin
				out_data   <= skid_reg;
				out_valid  <= 1'b1;
				skid_v_reg <= 1'b0;
			end else begin
				out_valid <= in_valid;
				out_data  <= in_data;
			end
		end else if (in_valid && !skid_v_reg) begin
			skid_v_reg <= 1'b1;
			skid_reg   <= in_data;
		end
	end
endmodule

// Functional notes
// - Two independent CPU injection groups feed core.
// - Injection obeys CPU port 11 congestion hold.
// - Host fills groups by registers or DMA.
// - Remote register engine may own one group.
// - With detection on, first 20 bytes are header.
// - One global field names external host port.
// - Queue mask sends queues to external host.
// - Per-port enable inserts extraction header on egress.
// - Per-port enable parses injection header on ingress.
// - External host uses a front port's Ethernet.
// - Prefix, then header, before destination MAC.
// - Header bit picks analyzer or direct destinations.
// - Multi-reason CPU frames go both ways.
// - Extraction header: 20 bytes, class, timestamp, reason.
// - Group-injected frames appear received on port 11.
module cfi_dev
	import cfi_pkg::*;
#(
	parameter cfi_port_t PORT_ID    = 4'd0,
	parameter int        PREFIX_LEN = 0
) (
	input  wire logic          sys_clk,
	input  wire logic          rst_b,
	cfi_link_if.dev            link,
	input  wire cfi_pkg::cfi_port_t  external_host_port_number,
	input  wire cfi_pkg::cfi_qmask_t external_host_queue_mask,
	input  wire logic          egress_extract_header_enable,
	input  wire logic [1:0]    ingress_inject_header_enable,
	input  wire logic          cpu_port_hold,
	input  wire logic [1:0]    inj_valid,
	input  wire logic [15:0]   inj_data,
	input  wire logic [1:0]    inj_last,
	output logic [1:0]         inj_ready,
	input  wire logic          rra_bind_en,
	input  wire logic          rra_bind_grp,
	input  wire logic          rra_valid,
	input  wire cfi_pkg::cfi_byte_t  rra_data,
	input  wire logic          rra_last,
	output logic               rra_ready,
	output logic               core_valid,
	output cfi_pkg::cfi_byte_t core_data,
	output logic               core_last,
	output cfi_pkg::cfi_port_t core_src_port,
	output logic               core_bypass,
	output cfi_pkg::cfi_dmask_t core_dest_mask,
	input  wire logic          core_ready,
	input  wire logic          xtr_valid,
	input  wire cfi_pkg::cfi_byte_t  xtr_data,
	input  wire logic          xtr_last,
	input  wire logic          xtr_fwd,
	input  wire logic          xtr_cpu,
	input  wire logic          xtr_multi,
	input  wire logic [2:0]    xtr_queue,
	input  wire logic [7:0]    xtr_reason,
	input  wire logic [15:0]   xtr_class,
	input  wire logic [31:0]   xtr_ts,
	output logic               xtr_ready,
	output logic               int_valid,
	output cfi_pkg::cfi_byte_t int_data,
	output logic               int_last,
	input  wire logic          int_ready
);
	localparam int XW = 9 + 1 + 1 + 1 + 3 + 8 + 16 + 32;
	if (PREFIX_LEN < 0 || PREFIX_LEN > 31) begin : pfx_chk
		$error("PREFIX_LEN out of range");
	end
	localparam logic [4:0] PFX_LAST = 5'(PREFIX_LEN - 1);

	// Group inputs, the register engine replacing the group it is bound to
	logic [1:0] eng_on, g_in_ready, g_valid, g_last, g_take;
	logic [7:0] g_data [2];
	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : grp
			logic [8:0] gd;
			assign eng_on[g] = rra_bind_en && (rra_bind_grp == 1'(g));
			assign inj_ready[g] = !eng_on[g] && g_in_ready[g];
			cfi_skid #(.W(9)) u_gbuf (
				.sys_clk  (sys_clk),
				.rst_b    (rst_b),
				.in_valid (eng_on[g] ? rra_valid : inj_valid[g]),
				.in_data  (eng_on[g] ? {rra_last, rra_data} : {inj_last[g], inj_data[8*g +: 8]}),
				.in_ready (g_in_ready[g]),
				.out_valid(g_valid[g]),
				.out_data (gd),
				.out_ready(g_take[g])
			);
			assign g_last[g] = gd[8];
			assign g_data[g] = gd[7:0];
		end
	endgenerate
	assign rra_ready = |(eng_on & g_in_ready);

	logic       l_valid, l_last, l_take;
	logic [7:0] l_data;
	cfi_skid #(.W(9)) u_lbuf (
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.in_valid (link.h2d_valid),
		.in_data  ({link.h2d_last, link.h2d_data}),
		.in_ready (link.h2d_ready),
		.out_valid(l_valid),
		.out_data ({l_last, l_data}),
		.out_ready(l_take)
	);

	// Ingress
	cfi_in_e    in_state_reg;
	logic [1:0] sel_reg;
	logic       hdr_on_reg, byp_reg;
	logic [4:0] in_cnt_reg;
	cfi_dmask_t dmask_reg;
	logic       s_valid, s_last, s_ready, s_take, grp_sel, core_free;
	logic [7:0] s_data;
	assign grp_sel   = sel_reg != 2'd0;
	assign core_free = !core_valid || core_ready;
	assign s_valid   = grp_sel ? g_valid[sel_reg[1]] : l_valid;
	assign s_data    = grp_sel ? g_data[sel_reg[1]] : l_data;
	assign s_last    = grp_sel ? g_last[sel_reg[1]] : l_last;
	always_comb begin
		s_ready = 1'b0;
		if (in_state_reg == IN_PFX || in_state_reg == IN_HDR)
			s_ready = 1'b1;
		else if (in_state_reg == IN_BODY)
			s_ready = core_free;
		if (grp_sel && cpu_port_hold)
			s_ready = 1'b0;
	end
	assign s_take    = s_valid && s_ready;
	assign l_take    = s_take && !grp_sel;
	assign g_take[0] = s_take && sel_reg == 2'd1;
	assign g_take[1] = s_take && sel_reg == 2'd2;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			in_state_reg <= IN_IDLE;
			sel_reg      <= 2'd0;
			hdr_on_reg   <= 1'b0;
			in_cnt_reg   <= 5'd0;
		end else begin
			case (in_state_reg)
				IN_IDLE: begin
					in_cnt_reg <= 5'd0;
					// Link first: the external host has no retry path
					if (l_valid) begin
						sel_reg      <= 2'd0;
						hdr_on_reg   <= ingress_inject_header_enable[0];
						in_state_reg <= (PREFIX_LEN > 0) ? IN_PFX :
							ingress_inject_header_enable[0] ? IN_HDR : IN_BODY;
					end else if ((g_valid[0] || g_valid[1]) && !cpu_port_hold) begin
						sel_reg      <= g_valid[0] ? 2'd1 : 2'd2;
						hdr_on_reg   <= ingress_inject_header_enable[1];
						in_state_reg <= ingress_inject_header_enable[1] ? IN_HDR : IN_BODY;
					end
				end
				IN_PFX: if (s_take) begin
					in_cnt_reg <= in_cnt_reg + 5'd1;
					if (s_last)
						in_state_reg <= IN_IDLE;
					else if (in_cnt_reg == PFX_LAST) begin
						in_cnt_reg   <= 5'd0;
						in_state_reg <= hdr_on_reg ? IN_HDR : IN_BODY;
					end
				end
				IN_HDR: if (s_take) begin
					in_cnt_reg <= in_cnt_reg + 5'd1;
					if (s_last)
						in_state_reg <= IN_IDLE;
					else if (in_cnt_reg == `CFI_HDR_LEN - 5'd1)
						in_state_reg <= IN_BODY;
				end
				IN_BODY: if (s_take && s_last)
					in_state_reg <= IN_IDLE;
				default: in_state_reg <= IN_IDLE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			byp_reg   <= 1'b0;
			dmask_reg <= '0;
		end else if (in_state_reg == IN_IDLE) begin
			byp_reg <= 1'b0;
		end else if (in_state_reg == IN_HDR && s_take) begin
			if (in_cnt_reg == `CFI_INJ_BYPASS)
				byp_reg <= s_data[0];
			if (in_cnt_reg == `CFI_INJ_DST_HI)
				dmask_reg[10:8] <= s_data[2:0];
			if (in_cnt_reg == `CFI_INJ_DST_LO)
				dmask_reg[7:0] <= s_data;
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			core_valid     <= 1'b0;
			core_data      <= 8'h00;
			core_last      <= 1'b0;
			core_src_port  <= 4'h0;
			core_bypass    <= 1'b0;
			core_dest_mask <= '0;
		end else if (core_free) begin
			core_valid     <= s_take && in_state_reg == IN_BODY;
			core_data      <= s_data;
			core_last      <= s_last;
			core_src_port  <= grp_sel ? `CFI_CPU_PORT : PORT_ID;
			core_bypass    <= hdr_on_reg && byp_reg;
			core_dest_mask <= dmask_reg;
		end
	end

	// Egress
	logic          x_valid, x_ready, x_last, x_fwd, x_cpu, x_multi;
	logic [2:0]    x_q;
	logic [7:0]    x_data, x_reason;
	logic [15:0]   x_class;
	logic [31:0]   x_ts;
	cfi_skid #(.W(XW)) u_xbuf (
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.in_valid (xtr_valid),
		.in_data  ({xtr_last, xtr_data, xtr_fwd, xtr_cpu, xtr_multi, xtr_queue,
			xtr_reason, xtr_class, xtr_ts}),
		.in_ready (xtr_ready),
		.out_valid(x_valid),
		.out_data ({x_last, x_data, x_fwd, x_cpu, x_multi, x_q, x_reason, x_class, x_ts}),
		.out_ready(x_ready)
	);

	cfi_eg_e     eg_state_reg;
	logic        to_link_reg, to_int_reg, is_host, to_host, lk_rdy, lk_push, int_free;
	logic [4:0]  eg_cnt_reg;
	logic [63:0] xhdr_reg;
	logic [7:0]  lk_data, hdr_byte;
	assign is_host  = external_host_port_number == PORT_ID;
	assign to_host  = x_cpu && is_host && external_host_queue_mask[x_q];
	assign int_free = !int_valid || int_ready;
	// Bytes beyond the eighth carry no fields and go out as zero
	assign hdr_byte = (eg_cnt_reg < 5'd8) ? xhdr_reg[8*eg_cnt_reg[2:0] +: 8] : 8'h00;
	assign lk_data  = (eg_state_reg == EG_HDR) ? hdr_byte :
		(eg_state_reg == EG_PFX) ? 8'h55 : x_data;
	always_comb begin
		lk_push = 1'b0;
		x_ready = 1'b0;
		if (eg_state_reg == EG_PFX || eg_state_reg == EG_HDR)
			lk_push = 1'b1;
		else if (eg_state_reg == EG_BODY) begin
			x_ready = (!to_link_reg || lk_rdy) && (!to_int_reg || int_free);
			lk_push = to_link_reg && x_valid && (!to_int_reg || int_free);
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			eg_state_reg <= EG_IDLE;
			eg_cnt_reg   <= 5'd0;
			to_link_reg  <= 1'b0;
			to_int_reg   <= 1'b0;
			xhdr_reg     <= '0;
		end else begin
			case (eg_state_reg)
				EG_IDLE: begin
					eg_cnt_reg <= 5'd0;
					if (x_valid) begin
						to_link_reg  <= x_fwd || to_host;
						to_int_reg   <= x_cpu && (!to_host || x_multi);
						xhdr_reg     <= {5'b0, x_q, x_reason, x_class, x_ts};
						eg_state_reg <= !(x_fwd || to_host) || !egress_extract_header_enable ?
							EG_BODY : (PREFIX_LEN > 0) ? EG_PFX : EG_HDR;
					end
				end
				EG_PFX: if (lk_rdy) begin
					eg_cnt_reg <= eg_cnt_reg + 5'd1;
					if (eg_cnt_reg == PFX_LAST) begin
						eg_cnt_reg   <= 5'd0;
						eg_state_reg <= EG_HDR;
					end
				end
				EG_HDR: if (lk_rdy) begin
					eg_cnt_reg <= eg_cnt_reg + 5'd1;
					if (eg_cnt_reg == `CFI_HDR_LEN - 5'd1)
						eg_state_reg <= EG_BODY;
				end
				EG_BODY: if (x_valid && x_ready && x_last)
					eg_state_reg <= EG_IDLE;
				default: eg_state_reg <= EG_IDLE;
			endcase
		end
	end

	cfi_skid #(.W(9)) u_obuf (
		.sys_clk  (sys_clk),
		.rst_b    (rst_b),
		.in_valid (lk_push),
		.in_data  ({eg_state_reg == EG_BODY && x_last, lk_data}),
		.in_ready (lk_rdy),
		.out_valid(link.d2h_valid),
		.out_data ({link.d2h_last, link.d2h_data}),
		.out_ready(link.d2h_ready)
	);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			int_valid <= 1'b0;
			int_data  <= 8'h00;
			int_last  <= 1'b0;
		end else if (int_free) begin
			int_valid <= eg_state_reg == EG_BODY && to_int_reg && x_valid && x_ready;
			int_data  <= x_data;
			int_last  <= x_last;
		end
	end
endmodule
`default_nettype wire

//--- cfi_regs.svh
/*
 * Constants of the CPU frame inject / external host link: header layout,
 * port numbers and the host controller's register map.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef CFI_REGS_SVH
`define CFI_REGS_SVH

`define CFI_HDR_LEN      5'd20
`define CFI_CPU_PORT     4'd11
`define CFI_INJ_BYPASS   5'd0
`define CFI_INJ_DST_HI   5'd1
`define CFI_INJ_DST_LO   5'd2
`define CFI_XTR_TS0      5'd0
`define CFI_XTR_CLS0     5'd4
`define CFI_XTR_REASON   5'd6
`define CFI_XTR_QUEUE    5'd7
`define CFI_WB_CTRL      8'h00
`define CFI_WB_STAT      8'h04
`define CFI_WB_CNT       8'h08
`define CFI_CTRL_INJ     0
`define CFI_CTRL_XTR     1
`define CFI_CTRL_BYP     2
`define CFI_CTRL_DST     16
`define CFI_CTRL_RST     32'h0000_0000

`endif

//--- cfi_pkg.sv
/*
 * Types shared by both ends of the CPU frame inject / external host link.
 * Assumes cfi_regs.svh sits in the same folder.
 */
`include "cfi_regs.svh"
package cfi_pkg;
	typedef logic [7:0]  cfi_byte_t;
	typedef logic [10:0] cfi_dmask_t;
	typedef logic [7:0]  cfi_qmask_t;
	typedef logic [3:0]  cfi_port_t;
	typedef enum logic [1:0] {IN_IDLE, IN_PFX, IN_HDR, IN_BODY} cfi_in_e;
	typedef enum logic [1:0] {EG_IDLE, EG_PFX, EG_HDR, EG_BODY} cfi_eg_e;
	typedef enum logic [1:0] {TX_IDLE, TX_PFX, TX_HDR, TX_BODY} cfi_tx_e;
endpackage

//--- cfi_link_if.sv
/*
 * Byte stream link of the front port between external host and device.
 * Assumes both ends share sys_clk; valid/ready on each direction.
 */
`timescale 1ns/1ps
`default_nettype none
interface cfi_link_if;
	logic       h2d_valid;
	logic [7:0] h2d_data;
	logic       h2d_last;
	logic       h2d_ready;
	logic       d2h_valid;
	logic [7:0] d2h_data;
	logic       d2h_last;
	logic       d2h_ready;
	modport dev  (input h2d_valid, h2d_data, h2d_last, d2h_ready,
		output h2d_ready, d2h_valid, d2h_data, d2h_last);
	modport host (output h2d_valid, h2d_data, h2d_last, d2h_ready,
		input h2d_ready, d2h_valid, d2h_data, d2h_last);
endinterface
`default_nettype wire

//--- cfi_host.sv
/*
 * External host end: builds injection frames with prefix and header, strips
 * prefix and extraction header from received frames, classic Wishbone slave.
 * Assumes cfi_dev on the other side of cfi_link_if with matching PREFIX_LEN.
 */
`timescale 1ns/1ps
`default_nettype none
`include "cfi_regs.svh"
module cfi_host
	import cfi_pkg::*;
#(
	parameter int PREFIX_LEN = 0
) (
	input  wire logic          sys_clk,
	input  wire logic          rst_b,
	cfi_link_if.host           link,
	input  wire logic          wb_cyc_i,
	input  wire logic          wb_stb_i,
	input  wire logic          wb_we_i,
	input  wire logic [7:0]    wb_adr_i,
	input  wire logic [3:0]    wb_sel_i,
	input  wire logic [31:0]   wb_dat_i,
	output logic [31:0]        wb_dat_o,
	output logic               wb_ack_o,
	input  wire logic          usr_tx_valid,
	input  wire cfi_pkg::cfi_byte_t usr_tx_data,
	input  wire logic          usr_tx_last,
	output logic               usr_tx_ready,
	output logic               usr_rx_valid,
	output cfi_pkg::cfi_byte_t usr_rx_data,
	output logic               usr_rx_last,
	input  wire logic          usr_rx_ready
);
	if (PREFIX_LEN < 0 || PREFIX_LEN > 31) begin : pfx_chk
		$error("PREFIX_LEN out of range");
	end
	localparam logic [5:0] PFX    = 6'(PREFIX_LEN);
	localparam logic [4:0] PFX_LS = 5'(PREFIX_LEN - 1);

	logic [31:0] ctrl_reg;
	logic [7:0]  reason_reg;
	logic [2:0]  queue_reg;
	logic [15:0] cnt_reg;
	logic        wb_req, wb_wr, rx_end;
	assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
	assign wb_wr  = wb_req && wb_we_i;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end else begin
			wb_ack_o <= wb_req;
			wb_dat_o <= 32'h0000_0000;
			if (wb_adr_i == `CFI_WB_CTRL)
				wb_dat_o <= ctrl_reg;
			else if (wb_adr_i == `CFI_WB_STAT)
				wb_dat_o <= {21'h0, queue_reg, reason_reg};
			else if (wb_adr_i == `CFI_WB_CNT)
				wb_dat_o <= {16'h0, cnt_reg};
		end
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			ctrl_reg <= `CFI_CTRL_RST;
		else if (wb_wr && wb_adr_i == `CFI_WB_CTRL) begin
			if (wb_sel_i[0])
				ctrl_reg[2:0] <= wb_dat_i[2:0];
			if (wb_sel_i[2])
				ctrl_reg[23:16] <= wb_dat_i[23:16];
			if (wb_sel_i[3])
				ctrl_reg[26:24] <= wb_dat_i[26:24];
		end
	end

	// Transmit: prefix, injection header, then the frame from its DMAC on
	cfi_tx_e    tx_state_reg;
	logic [4:0] tx_cnt_reg;
	logic [7:0] hbyte;
	logic       tx_free;
	assign tx_free = !link.h2d_valid || link.h2d_ready;
	assign usr_tx_ready = tx_state_reg == TX_BODY && tx_free;
	always_comb begin
		hbyte = 8'h00;
		if (tx_cnt_reg == `CFI_INJ_BYPASS)
			hbyte = {7'h0, ctrl_reg[`CFI_CTRL_BYP]};
		else if (tx_cnt_reg == `CFI_INJ_DST_HI)
			hbyte = {5'h0, ctrl_reg[`CFI_CTRL_DST+8 +: 3]};
		else if (tx_cnt_reg == `CFI_INJ_DST_LO)
			hbyte = ctrl_reg[`CFI_CTRL_DST +: 8];
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			tx_state_reg   <= TX_IDLE;
			tx_cnt_reg     <= 5'd0;
			link.h2d_valid <= 1'b0;
			link.h2d_data  <= 8'h00;
			link.h2d_last  <= 1'b0;
		end else if (tx_free) begin
			link.h2d_valid <= 1'b0;
			link.h2d_last  <= 1'b0;
			case (tx_state_reg)
				TX_IDLE: begin
					tx_cnt_reg <= 5'd0;
					if (usr_tx_valid)
						tx_state_reg <= !ctrl_reg[`CFI_CTRL_INJ] ? TX_BODY :
							(PREFIX_LEN > 0) ? TX_PFX : TX_HDR;
				end
				TX_PFX: begin
					link.h2d_valid <= 1'b1;
					link.h2d_data  <= 8'h55;
					tx_cnt_reg     <= tx_cnt_reg + 5'd1;
					if (tx_cnt_reg == PFX_LS) begin
						tx_cnt_reg   <= 5'd0;
						tx_state_reg <= TX_HDR;
					end
				end
				TX_HDR: begin
					link.h2d_valid <= 1'b1;
					link.h2d_data  <= hbyte;
					tx_cnt_reg     <= tx_cnt_reg + 5'd1;
					if (tx_cnt_reg == `CFI_HDR_LEN - 5'd1)
						tx_state_reg <= TX_BODY;
				end
				TX_BODY: if (usr_tx_valid) begin
					link.h2d_valid <= 1'b1;
					link.h2d_data  <= usr_tx_data;
					link.h2d_last  <= usr_tx_last;
					if (usr_tx_last)
						tx_state_reg <= TX_IDLE;
				end
				default: tx_state_reg <= TX_IDLE;
			endcase
		end
	end

	// Receive: byte position decides prefix, header or frame body
	logic [5:0] rx_pos_reg, hdr_end;
	logic       rx_take, in_body, rx_free;
	assign hdr_end = ctrl_reg[`CFI_CTRL_XTR] ? PFX + 6'(`CFI_HDR_LEN) : 6'd0;
	assign in_body = rx_pos_reg >= hdr_end;
	assign rx_free = !usr_rx_valid || usr_rx_ready;
	assign link.d2h_ready = !in_body || rx_free;
	assign rx_take = link.d2h_valid && link.d2h_ready;
	assign rx_end  = rx_take && link.d2h_last;

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			rx_pos_reg   <= 6'd0;
			reason_reg   <= 8'h00;
			queue_reg    <= 3'h0;
			usr_rx_valid <= 1'b0;
			usr_rx_data  <= 8'h00;
			usr_rx_last  <= 1'b0;
		end else begin
			if (rx_end)
				rx_pos_reg <= 6'd0;
			else if (rx_take && !in_body)
				rx_pos_reg <= rx_pos_reg + 6'd1;
			if (rx_take && rx_pos_reg == PFX + 6'(`CFI_XTR_REASON) && !in_body)
				reason_reg <= link.d2h_data;
			if (rx_take && rx_pos_reg == PFX + 6'(`CFI_XTR_QUEUE) && !in_body)
				queue_reg <= link.d2h_data[2:0];
			if (rx_free) begin
				usr_rx_valid <= rx_take && in_body;
				usr_rx_data  <= link.d2h_data;
				usr_rx_last  <= link.d2h_last;
			end
		end
	end

	// A frame ending in the clearing cycle still counts
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			cnt_reg <= 16'h0000;
		else if (wb_wr && wb_adr_i == `CFI_WB_CNT)
			cnt_reg <= rx_end ? 16'h0001 : 16'h0000;
		else if (rx_end)
			cnt_reg <= cnt_reg + 16'h0001;
	end
endmodule
`default_nettype wire

//--- cfi_link_properties.sv
/*
 Handshake and framing checks on the host/device link.
 Assumes it taps the one shared cfi_link_if; egress header insertion is on.
*/
`timescale 1ns/1ps
`default_nettype none
module cfi_link_properties (
	input wire logic       sys_clk,
	input wire logic       rst_b,
	input wire logic       h2d_valid,
	input wire logic [7:0] h2d_data,
	input wire logic       h2d_last,
	input wire logic       h2d_ready,
	input wire logic       d2h_valid,
	input wire logic [7:0] d2h_data,
	input wire logic       d2h_last,
	input wire logic       d2h_ready
);
	logic [7:0] dcnt;
	// Bytes seen so far in the current device-to-host frame
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			dcnt <= '0;
		else if (d2h_valid && d2h_ready)
			dcnt <= d2h_last ? 8'h00 : dcnt + 8'h01;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	sequence h_stall; h2d_valid && !h2d_ready; endsequence
	sequence d_stall; d2h_valid && !d2h_ready; endsequence
	h_hold_a: assert property (h_stall |=> h2d_valid && $stable(h2d_data))
		else $error("h2d byte changed while stalled");
	h_last_a: assert property (h_stall |=> $stable(h2d_last))
		else $error("h2d last changed while stalled");
	d_hold_a: assert property (d_stall |=> d2h_valid && $stable(d2h_data))
		else $error("d2h byte changed while stalled");
	d_last_a: assert property (d_stall |=> $stable(d2h_last))
		else $error("d2h last changed while stalled");
	h_wait_a: assert property (h2d_valid |-> ##[0:200] h2d_ready)
		else $error("device never took h2d byte");
	d_wait_a: assert property (d2h_valid |-> ##[0:200] d2h_ready)
		else $error("host never took d2h byte");
	link_idle_a: assert property ($rose(rst_b) |-> !h2d_valid && !d2h_valid)
		else $error("link busy right after reset");
	xtr_len_a: assert property (d2h_valid && d2h_ready && d2h_last |-> dcnt >= 8'h14)
		else $error("extracted frame shorter than header");
endmodule
`default_nettype wire

//--- tb_top.sv
/*
 Testbench joining device and host ends over one link.
 Assumes PREFIX_LEN 0 on both ends and PORT_ID 0 on the device.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cfi_regs.svh"
module tb_top;
	import cfi_pkg::*;
	logic sys_clk = 0, rst_b = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0, wb_ack_o;
	logic [7:0] wb_adr_i = '0;
	logic [3:0] wb_sel_i = 4'hF;
	logic [31:0] wb_dat_i = '0, wb_dat_o, xtr_ts = '0;
	logic usr_tx_valid = 0, usr_tx_last = 0, usr_tx_ready, usr_rx_valid, usr_rx_last;
	logic usr_rx_ready = 0, cpu_port_hold = 0, rra_bind_en = 0, rra_bind_grp = 0;
	cfi_byte_t usr_tx_data = '0, usr_rx_data, rra_data = '0, core_data, xtr_data = '0, int_data;
	cfi_port_t external_host_port_number = '0, core_src_port;
	cfi_qmask_t external_host_queue_mask = '0;
	logic egress_extract_header_enable = 0, rra_valid = 0, rra_last = 0, rra_ready;
	logic [1:0] ingress_inject_header_enable = '0, inj_valid = '0, inj_last = '0, inj_ready;
	logic [15:0] inj_data = '0, xtr_class = 16'h00C3;
	logic core_valid, core_last, core_bypass, core_ready = 0, int_valid, int_last, int_ready = 0;
	cfi_dmask_t core_dest_mask;
	logic xtr_valid = 0, xtr_last = 0, xtr_fwd = 0, xtr_cpu = 0, xtr_multi = 0, xtr_ready;
	logic [2:0] xtr_queue = '0;
	logic [7:0] xtr_reason = '0;
	logic [24:0] cq[$];
	logic [8:0] rq[$], iq[$], dq[$], hq[$];
	int n = 0, err_count = 0, checks_done = 0;
	always #20 sys_clk = ~sys_clk;
	cfi_link_if lk ();
	cfi_dev i_cfi_dev (.link(lk), .*);
	cfi_host i_cfi_host (.link(lk), .*);
	cfi_link_properties i_cfi_link_properties (.sys_clk(sys_clk), .rst_b(rst_b),
		.h2d_valid(lk.h2d_valid), .h2d_data(lk.h2d_data), .h2d_last(lk.h2d_last),
		.h2d_ready(lk.h2d_ready), .d2h_valid(lk.d2h_valid), .d2h_data(lk.d2h_data),
		.d2h_last(lk.d2h_last), .d2h_ready(lk.d2h_ready));
	// Sinks stall on uneven patterns so the two-entry buffers really fill
	always @(posedge sys_clk) begin
		n <= n + 1;
		core_ready <= n % 3 != 0;
		usr_rx_ready <= n % 4 != 1;
		int_ready <= n % 5 != 2;
		if (core_valid && core_ready)
			cq.push_back({core_last, core_src_port, core_bypass, core_dest_mask, core_data});
		if (usr_rx_valid && usr_rx_ready) rq.push_back({usr_rx_last, usr_rx_data});
		if (int_valid && int_ready) iq.push_back({int_last, int_data});
		if (lk.d2h_valid && lk.d2h_ready) dq.push_back({lk.d2h_last, lk.d2h_data});
		if (lk.h2d_valid && lk.h2d_ready) hq.push_back({lk.h2d_last, lk.h2d_data});
	end
	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			err_count++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task results;
		$display("checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
		wb_cyc_i <= 1; wb_stb_i <= 1; wb_we_i <= w; wb_adr_i <= a; wb_dat_i <= d;
		wb_sel_i <= 4'hF;
		do @(posedge sys_clk); while (wb_ack_o !== 1'b1);
		q = wb_dat_o;
		wb_cyc_i <= 0; wb_stb_i <= 0; wb_we_i <= 0;
		@(posedge sys_clk);
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		wb(1, a, d, q);
	endtask
	task rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		wb(0, a, '0, q);
		chk(q, e);
	endtask
	task drv(input int k, input logic v, input logic [7:0] d, input logic l);
		case (k)
			0: begin usr_tx_valid <= v; usr_tx_data <= d; usr_tx_last <= l; end
			1, 2: begin inj_valid[k-1] <= v; inj_data[8*(k-1)+:8] <= d; inj_last[k-1] <= l; end
			3: begin rra_valid <= v; rra_data <= d; rra_last <= l; end
			default: begin xtr_valid <= v; xtr_data <= d; xtr_last <= l; end
		endcase
	endtask
	function logic rdy(input int k);
		case (k)
			0: return usr_tx_ready;
			1, 2: return inj_ready[k-1];
			3: return rra_ready;
			default: return xtr_ready;
		endcase
	endfunction
	function int sz(input int w);
		case (w)
			0: return cq.size();
			1: return rq.size();
			2: return iq.size();
			3: return dq.size();
			default: return hq.size();
		endcase
	endfunction
	task send(input int k, input int len, input logic [7:0] b);
		for (int i = 0; i < len; i++) begin
			drv(k, 1, b + i[7:0], i == len - 1);
			do @(posedge sys_clk); while (rdy(k) !== 1'b1);
		end
		drv(k, 0, '0, 0);
		@(posedge sys_clk);
	endtask
	task waitq(input int w, input int len);
		for (int t = 0; t < 300 && sz(w) < len; t++) @(posedge sys_clk);
	endtask
	// Destination mask only means something on bypassed frames
	task cfr(input int len, input logic [7:0] b, input cfi_port_t s, input logic y,
		input cfi_dmask_t m);
		logic [24:0] g;
		waitq(0, len);
		for (int i = 0; i < len; i++) begin
			g = cq.pop_front();
			if (!y) g[18:8] = m;
			chk(g, {i == len - 1, s, y, m, b + i[7:0]});
		end
	endtask
	task sfr(input int w, input int len, input logic [7:0] b);
		waitq(w, len);
		for (int i = 0; i < len; i++)
			chk(w == 1 ? rq.pop_front() : iq.pop_front(), {i == len - 1, b + i[7:0]});
	endtask
	initial begin
		repeat (6) @(posedge sys_clk);
		rst_b <= 1;
		@(posedge sys_clk);
		rd(`CFI_WB_CTRL, `CFI_CTRL_RST);
		wr(8'h0C, 32'hFFFF_FFFF);
		rd(8'h0C, 32'h0000_0000);
		ingress_inject_header_enable <= 2'b01;
		wr(`CFI_WB_CTRL, 32'h00A5_0005);
		send(0, 6, 8'h10);
		cfr(6, 8'h10, 4'h0, 1, 11'h0A5);
		waitq(4, 26);
		chk(hq.size(), 26);
		chk({hq[0][7:0], hq[1][7:0], hq[2][7:0], hq[20][7:0]}, 32'h0100_A510);
		wr(`CFI_WB_CTRL, 32'h00A5_0001);
		send(0, 3, 8'h30);
		cfr(3, 8'h30, 4'h0, 0, 11'h0A5);
		ingress_inject_header_enable <= 2'b00;
		wr(`CFI_WB_CTRL, 32'h0000_0000);
		hq.delete();
		send(0, 4, 8'h40);
		cfr(4, 8'h40, 4'h0, 0, '0);
		chk(hq.size(), 4);
		chk(hq[0][7:0], 8'h40);
		cpu_port_hold <= 1;
		send(1, 2, 8'h50);
		repeat (3) @(posedge sys_clk);
		chk(cq.size(), 0);
		chk(inj_ready, 2'b10);
		cpu_port_hold <= 0;
		cfr(2, 8'h50, 4'hB, 0, '0);
		for (int g = 1; g < 3; g++) begin
			send(g, 3, 8'h60);
			cfr(3, 8'h60, 4'hB, 0, '0);
		end
		rra_bind_en <= 1;
		repeat (3) @(posedge sys_clk);
		chk(inj_ready[0], 1'b0);
		send(3, 2, 8'h70);
		cfr(2, 8'h70, 4'hB, 0, '0);
		rra_bind_en <= 0;
		egress_extract_header_enable <= 1;
		external_host_queue_mask <= 8'h08;
		wr(`CFI_WB_CTRL, 32'h0000_0002);
		xtr_cpu <= 1; xtr_queue <= 3'h3; xtr_reason <= 8'h5A; xtr_ts <= 32'h1234_5678;
		send(4, 5, 8'h80);
		sfr(1, 5, 8'h80);
		chk(dq.size(), 25);
		chk({dq[0][7:0], dq[3][7:0], dq[6][7:0], dq[7][7:0]}, 32'h7812_5A03);
		rd(`CFI_WB_STAT, 32'h0000_035A);
		chk(iq.size(), 0);
		xtr_multi <= 1;
		send(4, 3, 8'h90);
		sfr(1, 3, 8'h90);
		sfr(2, 3, 8'h90);
		xtr_multi <= 0;
		xtr_queue <= 3'h2;
		send(4, 2, 8'hA0);
		sfr(2, 2, 8'hA0);
		chk(rq.size(), 0);
		xtr_queue <= 3'h3;
		external_host_port_number <= 4'h5;
		send(4, 2, 8'hB0);
		sfr(2, 2, 8'hB0);
		chk(rq.size(), 0);
		rd(`CFI_WB_CNT, 32'h0000_0002);
		wr(`CFI_WB_CNT, 32'h0000_0000);
		rd(`CFI_WB_CNT, 32'h0000_0000);
		results;
	end
	// Well over fifty times the cycles the sequence above needs
	initial begin
		repeat (20000) @(posedge sys_clk);
		err_count++;
		results;
	end
endmodule
`default_nettype wire
